// >>> crc_byte_fold.sv
`timescale 1ns/1ps
`include "crc_unit_consts.svh"

module crc_byte_fold (
    // Operands
    input  wire logic [31:0] i_acc,
    input  wire logic [7:0]  i_byte,
    input  wire logic        i_poly16,
    // Result
    output logic [31:0]      o_acc
);
    logic [15:0] acc16;
    logic [31:0] acc32;

    always_comb begin
        acc16 = i_acc[15:0] ^ {i_byte, 8'h00};
        acc32 = i_acc ^ {24'h000000, i_byte};
        for (int i = 0; i < `BITS_PER_BYTE; i++) begin
            if (acc16[15]) begin
                acc16 = {acc16[14:0], 1'b0} ^ `POLY16;
            end else begin
                acc16 = {acc16[14:0], 1'b0};
            end
            if (acc32[0]) begin
                acc32 = {1'b0, acc32[31:1]} ^ `POLY32_REFLECTED;
            end else begin
                acc32 = {1'b0, acc32[31:1]};
            end
        end
        // Upper half is left alone in 16-bit mode so a mode change keeps it.
        o_acc = i_poly16 ? {i_acc[31:16], acc16} : acc32;
    end
endmodule // crc_byte_fold

// >>> crc_unit.sv
// Operation
// - 16-bit mode computes MSB-first with polynomial 0x1021.
// - 16-bit mode XORs the input byte into the accumulator's upper byte.
// - 16-bit mode does 8 left-shift steps, XORing 0x1021 on top bit.
// - 32-bit mode computes reflected CRC with generator 0x04C11DB7.
// - 32-bit mode XORs the input byte into the low byte.
// - 32-bit mode does 8 right-shift steps, XORing 0xEDB88320 on bit 0.
// - Control bit 4 selects 32-bit (zero) or 16-bit (one).
// - Writing one to control bit 3 loads the whole result.
// - Control bit 2 picks init value: all zeros or all ones.
// - Each byte written to the input register is folded immediately.
// - Two-bit pointer selects window byte and increments per access.
// - 32-bit mode maps pointer 0..3 to result bytes 0..3.
// - 16-bit mode maps pointers 0,2 to low byte, 1,3 high.
// - Result holds until initialised, window-written or fed another byte.
// - Control bits 7:5 read zero and ignore writes.
// - With scan enabled and a nonzero sector count, a control write starts a flash sector CRC.
// - The CPU is stalled while a flash scan runs.
// - Scan control holds enable bit 7 and start sector 4:0.
// - Sector count register holds a 6-bit count in bits 5:0.
`timescale 1ns/1ps
`include "crc_unit_consts.svh"

module crc_unit #(
    parameter int FLASH_ADDR_WIDTH = 16
) (
    // Clock and reset
    input  wire logic                        i_clk,
    input  wire logic                        i_reset_n,
    // Special function register bus
    input  wire logic [7:0]                  i_sfr_addr,
    input  wire logic                        i_sfr_wr,
    input  wire logic                        i_sfr_rd,
    input  wire logic [7:0]                  i_sfr_wdata,
    output logic      [7:0]                  o_sfr_rdata,
    // Flash read port
    output logic      [FLASH_ADDR_WIDTH-1:0] o_flash_addr,
    output logic                             o_flash_rd,
    input  wire logic [7:0]                  i_flash_data,
    // Core stall
    output logic                             o_cpu_stall
);
    import crc_unit_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic                  poly16;
    logic                  init_ones;
    logic [1:0]            ptr;
    logic                  scan_enable;
    logic [4:0]            start_sector;
    logic [5:0]            sector_count;
    logic [7:0]            flip;
    crc_word_type          result;
    scan_state_type        state;
    logic [FLASH_ADDR_WIDTH-1:0] scan_addr;
    logic [FLASH_ADDR_WIDTH-1:0] scan_left;

    logic                  next_poly16;
    logic                  next_init_ones;
    logic [1:0]            next_ptr;
    logic                  next_scan_enable;
    logic [4:0]            next_start_sector;
    logic [5:0]            next_sector_count;
    logic [7:0]            next_flip;
    crc_word_type          next_result;
    scan_state_type        next_state;
    logic [FLASH_ADDR_WIDTH-1:0] next_scan_addr;
    logic [FLASH_ADDR_WIDTH-1:0] next_scan_left;
    logic [7:0]            next_rdata;

    logic [7:0]            fold_byte;
    crc_word_type          folded;

    function automatic logic sel(input logic [7:0] a, input logic [7:0] want);
        sel = (a == want);
    endfunction

    // Window byte lane for a pointer value and mode.
    function automatic logic [1:0] lane(input logic [1:0] p, input logic m16);
        lane = m16 ? {1'b0, p[0]} : p;
    endfunction

    function automatic logic [7:0] reverse8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            reverse8[i] = v[7-i];
        end
    endfunction

    // ------------------------------------------------------------
    // Byte folding
    // ------------------------------------------------------------
    assign fold_byte = (state == SCAN_FOLD) ? i_flash_data : i_sfr_wdata;

    crc_byte_fold u_fold (
        .i_acc    (result),
        .i_byte   (fold_byte),
        .i_poly16 (poly16),
        .o_acc    (folded)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic ctl_wr;
    logic win_access;

    always_comb begin
        ctl_wr            = i_sfr_wr && sel(i_sfr_addr, `ADDR_CRC_CONTROL);
        win_access        = (i_sfr_wr || i_sfr_rd)
                            && sel(i_sfr_addr, `ADDR_RESULT_WINDOW);
        next_poly16       = poly16;
        next_init_ones    = init_ones;
        next_ptr          = ptr;
        next_scan_enable  = scan_enable;
        next_start_sector = start_sector;
        next_sector_count = sector_count;
        next_flip         = flip;
        next_result       = result;
        next_state        = state;
        next_scan_addr    = scan_addr;
        next_scan_left    = scan_left;

        unique case (state)
            SCAN_IDLE: begin
                if (ctl_wr) begin
                    next_poly16    = i_sfr_wdata[`CTL_POLY_SELECT_BIT];
                    next_init_ones = i_sfr_wdata[`CTL_INIT_VALUE_BIT];
                    next_ptr       = i_sfr_wdata[`CTL_PTR_MSB:`CTL_PTR_LSB];
                    if (i_sfr_wdata[`CTL_INIT_STROBE_BIT]) begin
                        next_result = i_sfr_wdata[`CTL_INIT_VALUE_BIT]
                                      ? `INIT_ONES : `INIT_ZEROS;
                    end
                    if (scan_enable && sector_count != 6'h00) begin
                        next_state     = SCAN_FETCH;
                        next_scan_addr = FLASH_ADDR_WIDTH'(
                            {start_sector, 9'h000});
                        next_scan_left = FLASH_ADDR_WIDTH'(
                            {sector_count, 9'h000});
                    end
                end
                if (i_sfr_wr && sel(i_sfr_addr, `ADDR_CRC_BYTE_INPUT)) begin
                    next_result = folded;
                end
                if (win_access) begin
                    next_ptr = ptr + 2'h1;
                    if (i_sfr_wr) begin
                        for (int b = 0; b < 4; b++) begin
                            if (lane(ptr, poly16) == 2'(b)) begin
                                next_result[b*8 +: 8] = i_sfr_wdata;
                            end
                        end
                    end
                end
                if (i_sfr_wr && sel(i_sfr_addr, `ADDR_FLASH_SCAN_CTRL)) begin
                    next_scan_enable  = i_sfr_wdata[`SCAN_ENABLE_BIT];
                    next_start_sector =
                        i_sfr_wdata[`SCAN_START_MSB:`SCAN_START_LSB];
                end
                if (i_sfr_wr && sel(i_sfr_addr, `ADDR_FLASH_SECT_COUNT)) begin
                    next_sector_count = i_sfr_wdata[`COUNT_MSB:0];
                end
                if (i_sfr_wr && sel(i_sfr_addr, `ADDR_BIT_FLIP)) begin
                    next_flip = reverse8(i_sfr_wdata);
                end
            end
            SCAN_FETCH: begin
                // Flash data is registered by the array, so fold one cycle later.
                next_state = SCAN_FOLD;
            end
            SCAN_FOLD: begin
                next_result    = folded;
                next_scan_addr = scan_addr + FLASH_ADDR_WIDTH'(1);
                next_scan_left = scan_left - FLASH_ADDR_WIDTH'(1);
                next_state     = (scan_left == FLASH_ADDR_WIDTH'(1))
                                 ? SCAN_IDLE : SCAN_FETCH;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = `RESET_BYTE;
        if (i_sfr_rd) begin
            unique case (1'b1)
                sel(i_sfr_addr, `ADDR_CRC_CONTROL):
                    next_rdata = {3'b000, poly16, 1'b0, init_ones, ptr};
                sel(i_sfr_addr, `ADDR_RESULT_WINDOW):
                    next_rdata = result[lane(ptr, poly16)*8 +: 8];
                sel(i_sfr_addr, `ADDR_FLASH_SCAN_CTRL):
                    next_rdata = {scan_enable, state == SCAN_IDLE, 1'b0,
                                  start_sector};
                sel(i_sfr_addr, `ADDR_FLASH_SECT_COUNT):
                    next_rdata = {2'b00, sector_count};
                sel(i_sfr_addr, `ADDR_BIT_FLIP):
                    next_rdata = flip;
                default:
                    next_rdata = `RESET_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            poly16       <= 1'b0;
            init_ones    <= 1'b0;
            ptr          <= 2'h0;
            scan_enable  <= 1'b0;
            start_sector <= 5'h00;
            sector_count <= 6'h00;
            flip         <= `RESET_BYTE;
            result       <= `INIT_ZEROS;
            state        <= SCAN_IDLE;
            scan_addr    <= '0;
            scan_left    <= '0;
            o_sfr_rdata  <= `RESET_BYTE;
        end else begin
            poly16       <= next_poly16;
            init_ones    <= next_init_ones;
            ptr          <= next_ptr;
            scan_enable  <= next_scan_enable;
            start_sector <= next_start_sector;
            sector_count <= next_sector_count;
            flip         <= next_flip;
            result       <= next_result;
            state        <= next_state;
            scan_addr    <= next_scan_addr;
            scan_left    <= next_scan_left;
            o_sfr_rdata  <= next_rdata;
        end
    end

    assign o_flash_addr = scan_addr;
    assign o_flash_rd   = (state == SCAN_FETCH);
    assign o_cpu_stall  = (state != SCAN_IDLE);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    init_load_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state == SCAN_IDLE && ctl_wr && i_sfr_wdata[3] && !scan_enable
        |=> result == ($past(i_sfr_wdata[2]) ? 32'hffffffff : 32'h0))
        else $error("init strobe did not load result");
    ptr_step_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state == SCAN_IDLE && win_access |=> ptr == $past(ptr) + 2'h1)
        else $error("pointer did not increment");
    hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state == SCAN_IDLE && !i_sfr_wr |=> $stable(result))
        else $error("result changed without cause");
    unused_zero_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_sfr_rd && i_sfr_addr == 8'h91 |=> o_sfr_rdata[7:5] == 3'b000)
        else $error("unused control bits read nonzero");
    fold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state == SCAN_IDLE && i_sfr_wr && i_sfr_addr == 8'h94
        |=> result == $past(folded))
        else $error("input byte not folded");
    scan_start_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state == SCAN_IDLE && ctl_wr && scan_enable && sector_count != 0
        |=> o_cpu_stall && o_flash_addr == {start_sector, 9'h000})
        else $error("scan did not start");
    stall_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_cpu_stall |-> state != SCAN_IDLE)
        else $error("stall outside scan");
    upper_keep_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        poly16 && state == SCAN_IDLE && i_sfr_wr && i_sfr_addr == 8'h94
        |=> result[31:16] == $past(result[31:16]))
        else $error("16-bit fold touched upper half");
    // A window write lands in the byte that the pointer named before it moved.
    win_write_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state == SCAN_IDLE && win_access && i_sfr_wr && !poly16
        |=> result[$past(ptr)*8 +: 8] == $past(i_sfr_wdata))
        else $error("window write missed its byte");
    win_read32_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state == SCAN_IDLE && i_sfr_rd && i_sfr_addr == 8'hd9 && !poly16
        |=> o_sfr_rdata == $past(result[ptr*8 +: 8]))
        else $error("32-bit window read wrong byte");
    win_read16_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state == SCAN_IDLE && i_sfr_rd && i_sfr_addr == 8'hd9 && poly16
        |=> o_sfr_rdata
            == ($past(ptr[0]) ? $past(result[15:8]) : $past(result[7:0])))
        else $error("16-bit window read wrong byte");
    zero_count_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state == SCAN_IDLE && ctl_wr && sector_count == 6'h00
        |=> !o_cpu_stall)
        else $error("zero sector count started a scan");
    // Bus writes are dropped while the core is held, so only a fold may move the result.
    scan_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state == SCAN_FETCH
        |=> $stable(result))
        else $error("result moved while fetching");
    fetch_step_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state == SCAN_FOLD
        |=> o_flash_addr == $past(o_flash_addr) + FLASH_ADDR_WIDTH'(1))
        else $error("scan address did not advance");
endmodule // crc_unit

// >>> crc_unit_consts.svh
`ifndef CRC_UNIT_CONSTS_SVH
`define CRC_UNIT_CONSTS_SVH

// Register addresses on the special function register bus.
`define ADDR_CRC_CONTROL      8'h91
`define ADDR_CRC_BYTE_INPUT   8'h94
`define ADDR_BIT_FLIP         8'h95
`define ADDR_FLASH_SCAN_CTRL  8'h96
`define ADDR_FLASH_SECT_COUNT 8'h97
`define ADDR_RESULT_WINDOW    8'hd9

// Control register fields.
`define CTL_POLY_SELECT_BIT   4
`define CTL_INIT_STROBE_BIT   3
`define CTL_INIT_VALUE_BIT    2
`define CTL_PTR_MSB           1
`define CTL_PTR_LSB           0

// Flash scan control fields.
`define SCAN_ENABLE_BIT       7
`define SCAN_DONE_BIT         6
`define SCAN_START_MSB        4
`define SCAN_START_LSB        0
`define COUNT_MSB             5

// Polynomials and initial values.
`define POLY16                16'h1021
`define POLY32_REFLECTED      32'hedb88320
`define INIT_ZEROS            32'h00000000
`define INIT_ONES             32'hffffffff
`define BITS_PER_BYTE         8

// Flash geometry: a sector is 512 bytes.
`define SECTOR_SHIFT          9
`define RESET_BYTE            8'h00

`endif

// >>> crc_unit_pkg.sv
package crc_unit_pkg;
    typedef enum logic [1:0] {
        SCAN_IDLE,
        SCAN_FETCH,
        SCAN_FOLD
    } scan_state_type;

    typedef logic [31:0] crc_word_type;
endpackage

// >>> flash_array_model.sv
`timescale 1ns/1ps

module flash_array_model (
    // Clock
    input  wire logic        i_clk,
    // Flash read port
    input  wire logic [15:0] i_flash_addr,
    input  wire logic        i_flash_rd,
    output logic      [7:0]  o_flash_data = 8'ha5
);
    // Idle cycles show the inverted byte, so a stale value is never taken as fresh.
    always_ff @(posedge i_clk) begin
        if (i_flash_rd) begin
            o_flash_data <= i_flash_addr[7:0] ^ {i_flash_addr[9:8], 6'h15};
        end else begin
            o_flash_data <= ~o_flash_data;
        end
    end
endmodule // flash_array_model

// >>> tb.sv
`timescale 1ns/1ps
`include "crc_unit_consts.svh"

module tb;
    import crc_unit_pkg::*;
    localparam logic [7:0] CTL = `ADDR_CRC_CONTROL;
    localparam logic [7:0] DIN = `ADDR_CRC_BYTE_INPUT;
    localparam logic [7:0] WIN = `ADDR_RESULT_WINDOW;
    typedef struct {
        logic         poly;
        int           n;
        logic [39:0]  d;
        crc_word_type exp;
    } row_type;
    logic         i_clk;
    logic         i_reset_n;
    logic         i_sfr_wr;
    logic         i_sfr_rd;
    logic [7:0]   i_sfr_addr;
    logic [7:0]   i_sfr_wdata;
    logic [7:0]   o_sfr_rdata;
    logic [7:0]   i_flash_data;
    logic [15:0]  o_flash_addr;
    logic         o_flash_rd;
    logic         o_cpu_stall;
    logic [7:0]   b;
    crc_word_type e;
    int           n;
    int           cnt;
    int           failures = 0;
    int           checks = 0;
    row_type      rows[6] = '{
        '{1'b1, 1, 40'h6300000000, 32'h0000bd35},
        '{1'b1, 3, 40'haabbcc0000, 32'h00006cf6},
        '{1'b1, 5, 40'h0000aabbcc, 32'h0000b166},
        '{1'b0, 1, 40'h6300000000, 32'hf9462090},
        '{1'b0, 3, 40'haabbcc0000, 32'h41b207b3},
        '{1'b0, 5, 40'h0000aabbcc, 32'h78d129bc}};

    crc_unit u_crc_unit (
        .i_clk        (i_clk),
        .i_reset_n    (i_reset_n),
        .i_sfr_addr   (i_sfr_addr),
        .i_sfr_wr     (i_sfr_wr),
        .i_sfr_rd     (i_sfr_rd),
        .i_sfr_wdata  (i_sfr_wdata),
        .o_sfr_rdata  (o_sfr_rdata),
        .o_flash_addr (o_flash_addr),
        .o_flash_rd   (o_flash_rd),
        .i_flash_data (i_flash_data),
        .o_cpu_stall  (o_cpu_stall)
    );

    flash_array_model u_flash_array_model (
        .i_clk        (i_clk),
        .i_flash_addr (o_flash_addr),
        .i_flash_rd   (o_flash_rd),
        .o_flash_data (i_flash_data)
    );

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    // ------------------------------------------------------------------
    // Reference arithmetic and bus tasks
    // ------------------------------------------------------------------
    function automatic crc_word_type c16(input crc_word_type a, input logic [7:0] x);
        logic [15:0] r;
        r = a[15:0] ^ {x, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ({r[14:0], 1'b0} ^ 16'h1021) : {r[14:0], 1'b0};
        end
        return {16'h0000, r};
    endfunction

    function automatic crc_word_type c32(input crc_word_type a, input logic [7:0] x);
        crc_word_type r;
        r = a ^ {24'h000000, x};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ 32'hedb88320) : (r >> 1);
        end
        return r;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_sfr_addr = a;
        i_sfr_wdata = d;
        i_sfr_wr = 1'b1;
        @(negedge i_clk);
        i_sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        i_sfr_addr = a;
        i_sfr_rd = 1'b1;
        @(negedge i_clk);
        d = o_sfr_rdata;
        i_sfr_rd = 1'b0;
    endtask

    // Reads all four window slots from pointer zero; 16-bit mode repeats two bytes.
    task automatic rd_result(input logic poly, input crc_word_type r);
        logic [7:0] v;
        for (int p = 0; p < 4; p++) begin
            rd(WIN, v);
            chk(v, poly ? r[8*(p%2)+:8] : r[8*p+:8], "window byte");
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        i_reset_n = 1'b0;
        i_sfr_wr = 1'b0;
        i_sfr_rd = 1'b0;
        i_sfr_addr = 8'h00;
        i_sfr_wdata = 8'h00;
        repeat (20) @(negedge i_clk);
        i_reset_n = 1'b1;
        rd(CTL, b);
        chk(b, 8'h00, "control after reset");
        rd_result(1'b0, 32'h00000000);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(CTL, rows[i].poly ? 8'h1c : 8'h0c);
            for (int k = 0; k < rows[i].n; k++) begin
                wr(DIN, rows[i].d[39-8*k -: 8]);
            end
            wr(CTL, {3'b000, rows[i].poly, 4'h0});
            rd_result(rows[i].poly, rows[i].exp);
        end
        $display("test table done");
        wr(CTL, 8'h08);
        wr(DIN, 8'h63);
        wr(CTL, 8'he0);
        rd(CTL, b);
        chk(b, 8'h00, "unused control bits");
        rd_result(1'b0, c32(32'h00000000, 8'h63));
        wr(CTL, 8'h18);
        wr(DIN, 8'h63);
        wr(CTL, 8'h10);
        rd_result(1'b1, c16(32'h00000000, 8'h63));
        wr(CTL, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(WIN, 8'(8'h11 * (k + 1)));
        end
        wr(DIN, 8'h5a);
        wr(CTL, 8'h00);
        rd_result(1'b0, c32(32'h44332211, 8'h5a));
        rd(8'h80, b);
        chk(b, 8'h00, "unmapped read");
        $display("test init and window done");
        wr(CTL, 8'h0c);
        wr(`ADDR_FLASH_SCAN_CTRL, 8'h81);
        wr(`ADDR_FLASH_SECT_COUNT, 8'h01);
        wr(CTL, 8'h00);
        n = 0;
        while (o_flash_rd !== 1'b1 && n < 10) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 10) begin
            failures++;
            $display("mismatch at %0t: scan never fetched", $time);
            end_of_test();
        end
        chk(o_cpu_stall, 1'b1, "stall during scan");
        chk(o_flash_addr, 16'h0200, "first scan address");
        cnt = 0;
        while (o_cpu_stall === 1'b1 && n < 2000) begin
            cnt += (o_flash_rd === 1'b1);
            @(negedge i_clk);
            n++;
        end
        if (n >= 2000) begin
            failures++;
            $display("mismatch at %0t: scan never finished", $time);
            end_of_test();
        end
        chk(cnt, 512, "bytes fetched");
        wr(`ADDR_FLASH_SCAN_CTRL, 8'h01);
        wr(CTL, 8'h00);
        e = 32'hffffffff;
        for (int a = 512; a < 1024; a++) begin
            e = c32(e, a[7:0] ^ {a[9:8], 6'h15});
        end
        rd_result(1'b0, e);
        $display("test flash scan done");
        rd(`ADDR_FLASH_SCAN_CTRL, b);
        chk(b, 8'h41, "scan control readback");
        wr(`ADDR_FLASH_SECT_COUNT, 8'hff);
        rd(`ADDR_FLASH_SECT_COUNT, b);
        chk(b, 8'h3f, "sector count field");
        wr(`ADDR_BIT_FLIP, 8'hc0);
        rd(`ADDR_BIT_FLIP, b);
        chk(b, 8'h03, "bit flip c0");
        wr(`ADDR_BIT_FLIP, 8'h05);
        rd(`ADDR_BIT_FLIP, b);
        chk(b, 8'ha0, "bit flip 05");
        $display("test side registers done");
        wr(`ADDR_FLASH_SCAN_CTRL, 8'h81);
        wr(CTL, 8'h00);
        repeat (4) @(negedge i_clk);
        chk(o_cpu_stall, 1'b1, "stall before reset");
        i_reset_n = 1'b0;
        repeat (2) @(negedge i_clk);
        i_reset_n = 1'b1;
        @(negedge i_clk);
        chk(o_cpu_stall, 1'b0, "stall after reset");
        chk(o_flash_rd, 1'b0, "flash read after reset");
        rd(`ADDR_FLASH_SECT_COUNT, b);
        chk(b, 8'h00, "count after reset");
        rd(`ADDR_FLASH_SCAN_CTRL, b);
        chk(b, 8'h40, "scan control after reset");
        rd_result(1'b0, 32'h00000000);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule // tb
